//--- hw/mii_phy_timing.sv
// cycle model of transceiver mii latencies for 100 and 10 mb/s
// How it works
// - at 100 mb/s the j code starts 6 bit times after the tx clock edge seeing tx_en rise.
// - at 100 mb/s the t code starts 6 bit times after the tx clock edge seeing tx_en fall.
// - a bit time is 10 ns at 100 mb/s and 100 ns at 10 mb/s.
// - at 100 mb/s carrier sense rises 20 bit times and data arrives 24 bit times after the j code.
// - at 100 mb/s carrier sense falls 24 bit times after the t code.
// - at 10 mb/s tx_en and the nibble are sampled on the falling tx clock edge.
// - at 10 mb/s line drive starts 3.5 bit times after the sampling edge of the frame start.
// - a 10 mb/s frame ends with a high level of nominally 300 ns and at least 250 ns.
// - at 10 mb/s carrier sense rises 630 ns, at most 1000 ns, after line activity.
// - at 10 mb/s rx_dv rises 10 bit times after the first preamble bit.
// - switching rx clock sources may stretch a clock phase but never shorten one.
module mii_phy_timing (
   input  wire logic                               core_clk_in,
   input  wire logic                               sys_rst_in,
   input  wire logic                               tx_clk_in,
   input  wire logic                               tx_en_in,
   input  wire logic [mii_timing_pkg::NIB_W-1:0]   txd_in,
   input  wire logic                               speed_10_in,
   input  wire logic                               line_rx_act_in,
   input  wire logic [mii_timing_pkg::NIB_W-1:0]   line_rxd_in,
   output logic                                    line_j_out,
   output logic                                    line_t_out,
   output logic                                    line_tx_active_out,
   output logic [mii_timing_pkg::NIB_W-1:0]        line_txd_out,
   output logic                                    line_eop_out,
   output logic                                    crs_out,
   output logic                                    rx_dv_out,
   output logic [mii_timing_pkg::NIB_W-1:0]        rxd_out,
   output logic                                    rx_clk_out
);
   import mii_timing_pkg::*;

   // ---------------------------------------------------------------
   // input synchronisers: a change counts once stages 2 and 3 agree
   // ---------------------------------------------------------------
   logic [SYN_W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
   logic [SYN_W-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_filt, agree;

   always_comb begin
      nxt_s1   = {speed_10_in, line_rxd_in, line_rx_act_in, txd_in,
                  tx_en_in, tx_clk_in};
      nxt_s2   = s1_ff;
      nxt_s3   = s2_ff;
      agree    = ~(s2_ff ^ s3_ff);
      nxt_filt = (agree & s3_ff) | (~agree & filt_ff);
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
         filt_ff <= '0;
      end else begin
         s1_ff   <= nxt_s1;
         s2_ff   <= nxt_s2;
         s3_ff   <= nxt_s3;
         filt_ff <= nxt_filt;
      end
   end

   logic             tclk, ten, rxact, spd;
   logic [NIB_W-1:0] tdat, rdat;
   assign tclk  = filt_ff[SY_TXCLK];
   assign ten   = filt_ff[SY_TXEN];
   assign tdat  = filt_ff[SY_TXD +: NIB_W];
   assign rxact = filt_ff[SY_RXACT];
   assign rdat  = filt_ff[SY_RXD +: NIB_W];
   assign spd   = filt_ff[SY_SPD];

   // ---------------------------------------------------------------
   // transmit sampling on the tx clock edge chosen by speed
   // ---------------------------------------------------------------
   logic             clk_prev_ff, en_samp_ff, nxt_clk_prev, nxt_en_samp;
   logic [NIB_W-1:0] d_samp_ff, nxt_d_samp;
   logic             rise, fall, samp, tx_start, tx_stop;
   logic             ten_q_ff, nxt_ten_q;
   logic [NIB_W-1:0] tdat_q_ff, nxt_tdat_q;

   always_comb begin
      rise     = tclk & ~clk_prev_ff;
      fall     = ~tclk & clk_prev_ff;
      // the mac moves data on the rising edge, so falling is safe
      samp     = spd ? fall : rise;
      // values of one cycle back: data launched by this very edge can
      // clear the filter in the same cycle as the edge (zero hold)
      tx_start = samp & ten_q_ff & ~en_samp_ff;
      tx_stop  = samp & ~ten_q_ff & en_samp_ff;
      nxt_clk_prev = tclk;
      nxt_ten_q    = ten;
      nxt_tdat_q   = tdat;
      nxt_en_samp  = samp ? ten_q_ff : en_samp_ff;
      nxt_d_samp   = samp ? tdat_q_ff : d_samp_ff;
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         clk_prev_ff <= 1'b0;
         en_samp_ff  <= 1'b0;
         d_samp_ff   <= '0;
         ten_q_ff    <= 1'b0;
         tdat_q_ff   <= '0;
      end else begin
         clk_prev_ff <= nxt_clk_prev;
         en_samp_ff  <= nxt_en_samp;
         d_samp_ff   <= nxt_d_samp;
         ten_q_ff    <= nxt_ten_q;
         tdat_q_ff   <= nxt_tdat_q;
      end
   end

   // ---------------------------------------------------------------
   // transmit delay lines; one stage less, the output flop adds it
   // ---------------------------------------------------------------
   logic [1:0] fast_d, slow_d;
   logic       fast_j_d, fast_t_d;

   pulse_delay #(.WIDTH(1), .DEPTH(TX_FAST_CYC - 1)) u_tx_fast_j (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     (tx_start & ~spd),
      .data_out    (fast_j_d)
   );
   pulse_delay #(.WIDTH(1), .DEPTH(TX_FAST_END_CYC - 1)) u_tx_fast_t (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     (tx_stop & ~spd),
      .data_out    (fast_t_d)
   );
   assign fast_d = {fast_t_d, fast_j_d};
   pulse_delay #(.WIDTH(2), .DEPTH(TX_SLOW_CYC - 1)) u_tx_slow (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     ({tx_stop & spd, tx_start & spd}),
      .data_out    (slow_d)
   );

   // ---------------------------------------------------------------
   // line side: code markers, drive window, end-of-frame high level
   // ---------------------------------------------------------------
   logic             j_ff, t_ff, act_ff, eop_ff;
   logic             nxt_j, nxt_t, nxt_act, nxt_eop;
   logic [NIB_W-1:0] ltxd_ff, nxt_ltxd;
   logic [EOP_W-1:0] eop_cnt_ff, nxt_eop_cnt;

   always_comb begin
      nxt_j       = fast_d[0];
      nxt_t       = fast_d[1];
      nxt_act     = act_ff;
      nxt_eop     = eop_ff;
      nxt_eop_cnt = eop_cnt_ff;
      nxt_ltxd    = d_samp_ff;
      if (fast_d[0] | slow_d[0]) begin
         nxt_act = 1'b1;
      end else if (fast_d[1] | slow_d[1]) begin
         nxt_act = 1'b0;
      end
      // same high time whatever the last bit was
      if (slow_d[1]) begin
         nxt_eop     = 1'b1;
         nxt_eop_cnt = '0;
      end else if (eop_ff) begin
         if (eop_cnt_ff == EOP_W'(EOP_CYC - 1)) begin
            nxt_eop = 1'b0;
         end else begin
            nxt_eop_cnt = eop_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         j_ff       <= 1'b0;
         t_ff       <= 1'b0;
         act_ff     <= 1'b0;
         eop_ff     <= 1'b0;
         eop_cnt_ff <= '0;
         ltxd_ff    <= '0;
      end else begin
         j_ff       <= nxt_j;
         t_ff       <= nxt_t;
         act_ff     <= nxt_act;
         eop_ff     <= nxt_eop;
         eop_cnt_ff <= nxt_eop_cnt;
         ltxd_ff    <= nxt_ltxd;
      end
   end

   assign line_j_out         = j_ff;
   assign line_t_out         = t_ff;
   assign line_tx_active_out = act_ff;
   assign line_txd_out       = ltxd_ff;
   assign line_eop_out       = eop_ff;

   // ---------------------------------------------------------------
   // receive delay lines for carrier and data, per speed
   // ---------------------------------------------------------------
   logic             fon_d, son_d;
   logic [NIB_W:0]   fdat_d, sdat_d;

   pulse_delay #(.WIDTH(1), .DEPTH(CRS_ON_FAST_CYC - 1)) u_rx_fon (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     (rxact),
      .data_out    (fon_d)
   );
   pulse_delay #(.WIDTH(NIB_W + 1), .DEPTH(DATA_FAST_CYC - 1)) u_rx_fdat (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     ({rdat, rxact}),
      .data_out    (fdat_d)
   );
   pulse_delay #(.WIDTH(1), .DEPTH(CRS_ON_SLOW_CYC - 1)) u_rx_son (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     (rxact),
      .data_out    (son_d)
   );
   pulse_delay #(.WIDTH(NIB_W + 1), .DEPTH(DV_SLOW_CYC - 1)) u_rx_sdat (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .data_in     ({rdat, rxact}),
      .data_out    (sdat_d)
   );

   // ---------------------------------------------------------------
   // carrier sense and receive data; crs spans early-on to late-off
   // ---------------------------------------------------------------
   logic             crs_ff, dv_ff, nxt_crs, nxt_dv;
   logic [NIB_W-1:0] rxd_ff, nxt_rxd;

   always_comb begin
      if (spd) begin
         nxt_crs = son_d | sdat_d[0];
         nxt_dv  = sdat_d[0];
         nxt_rxd = sdat_d[NIB_W:1];
      end else begin
         nxt_crs = fon_d | fdat_d[0];
         nxt_dv  = fdat_d[0];
         nxt_rxd = fdat_d[NIB_W:1];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         crs_ff <= 1'b0;
         dv_ff  <= 1'b0;
         rxd_ff <= '0;
      end else begin
         crs_ff <= nxt_crs;
         dv_ff  <= nxt_dv;
         rxd_ff <= nxt_rxd;
      end
   end

   assign crs_out   = crs_ff;
   assign rx_dv_out = dv_ff;
   assign rxd_out   = rxd_ff;

   // ---------------------------------------------------------------
   // rx clock: source follows carrier; a switch restarts the phase
   // ---------------------------------------------------------------
   logic            rclk_ff, src_ff, nxt_rclk, nxt_src;
   logic [PH_W-1:0] ph_ff, nxt_ph, ph_len;

   always_comb begin
      ph_len   = spd ? PH_W'(RXCLK_SLOW_CYC)
                     : (rclk_ff ? PH_W'(RXCLK_HI_CYC) : PH_W'(RXCLK_LO_CYC));
      nxt_src  = crs_ff;
      nxt_rclk = rclk_ff;
      nxt_ph   = ph_ff + 1'b1;
      // stretching is safe, toggling early would break the mac
      if (src_ff != crs_ff) begin
         nxt_ph = '0;
      end else if (ph_ff >= ph_len - 1'b1) begin
         nxt_rclk = ~rclk_ff;
         nxt_ph   = '0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rclk_ff <= 1'b0;
         src_ff  <= 1'b0;
         ph_ff   <= '0;
      end else begin
         rclk_ff <= nxt_rclk;
         src_ff  <= nxt_src;
         ph_ff   <= nxt_ph;
      end
   end

   assign rx_clk_out = rclk_ff;

   // ---------------------------------------------------------------
   // checks: helper counters for hold times
   // ---------------------------------------------------------------
   logic [EOP_W-1:0] eop_len_ff;
   logic [PH_W:0]    hold_ff;
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         eop_len_ff <= '0;
         hold_ff    <= '0;
      end else begin
         eop_len_ff <= eop_ff ? eop_len_ff + 1'b1 : '0;
         hold_ff    <= (rclk_ff != nxt_rclk) ? '0 : hold_ff + 1'b1;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   j_latency_a: assert property (tx_start && !spd |-> ##8 line_j_out)
      else $error("j code late or missing");
   t_latency_a: assert property (tx_stop && !spd |-> ##8 line_t_out)
      else $error("t code late or missing");
   crs_on_fast_a: assert property (
      $rose(rxact) && !spd ##1 (rxact && !spd)[*8]
      |-> ##16 !crs_out ##1 crs_out)
      else $error("fast carrier on not at 25 cycles");
   crs_off_fast_a: assert property (
      $fell(rxact) && !spd ##1 (!spd)[*8]
      |-> ##21 crs_out ##1 !crs_out)
      else $error("fast carrier off not at 30 cycles");
   fall_sample_a: assert property (
      samp && spd |-> !tclk && $past(tclk))
      else $error("slow sample not on falling edge");
   tx_slow_lat_a: assert property (
      tx_start && spd |-> ##44 line_tx_active_out)
      else $error("slow line drive late");
   eop_hold_a: assert property (
      $fell(line_eop_out) |-> $past(eop_len_ff) >= EOP_W'(EOP_MIN_CYC - 1))
      else $error("end of frame high too short");
   crs_on_slow_a: assert property (
      $rose(rxact) && spd ##1 (rxact && spd)[*8]
      |-> ##70 !crs_out ##1 crs_out)
      else $error("slow carrier on not at 79 cycles");
   dv_slow_a: assert property (
      $rose(rxact) && spd ##1 (rxact && spd)[*8]
      |-> ##116 !rx_dv_out ##1 rx_dv_out)
      else $error("slow rx_dv not at 125 cycles");
   // floor follows the speed that decided the toggle
   rxclk_phase_a: assert property (
      $changed(rx_clk_out) |-> $past(hold_ff) >= ($past(spd)
      ? (PH_W + 1)'(RXCLK_SLOW_MIN_CYC - 1)
      : (PH_W + 1)'(RXCLK_FAST_MIN_CYC - 1)))
      else $error("rx clock phase shortened");

   tx_fast_c: cover property (tx_start && !spd ##8 line_j_out);
   tx_slow_c: cover property ($rose(line_eop_out));
   rx_fast_c: cover property ($rose(crs_out) && !spd);
   rx_slow_c: cover property ($rose(rx_dv_out) && spd);
endmodule : mii_phy_timing

//--- hw/mii_timing_pkg.sv
// package: latency figures and cycle counts for the mii timing model
package mii_timing_pkg;
   // ---------------------------------------------------------------
   // clock and bit times
   // ---------------------------------------------------------------
   localparam int CLK_NS      = 8;    // core clock period
   localparam int BIT_NS_FAST = 10;
   localparam int BIT_NS_SLOW = 100;
   localparam int NIB_W       = 4;

   // ---------------------------------------------------------------
   // documented latencies, in their own units
   // ---------------------------------------------------------------
   localparam int TX_FAST_LAT_BITS      = 6;
   localparam int TX_FAST_END_BITS      = 6;
   localparam int TX_SLOW_LAT_HALF_BITS = 7;    // 3.5 bit times
   localparam int RX_CRS_ON_FAST_BITS   = 20;
   localparam int RX_DATA_FAST_BITS     = 24;
   localparam int RX_CRS_OFF_FAST_BITS  = 24;
   localparam int RX_CRS_ON_SLOW_NS     = 630;
   localparam int RX_CRS_ON_SLOW_MAX_NS = 1000;
   localparam int RX_DV_SLOW_BITS       = 10;
   localparam int EOP_NOM_NS            = 300;
   localparam int EOP_MIN_NS            = 250;
   localparam int RXCLK_FAST_HI_NS      = 24;
   localparam int RXCLK_FAST_LO_NS      = 16;
   localparam int RXCLK_SLOW_PH_NS      = 200;
   localparam int RXCLK_FAST_MIN_NS     = 16;
   localparam int RXCLK_SLOW_MIN_NS     = 160;

   // ---------------------------------------------------------------
   // cycle counts: latencies round up to whole core cycles, the slow carrier-on maximum rounds down
   // ---------------------------------------------------------------
   localparam int TX_FAST_CYC = (TX_FAST_LAT_BITS * BIT_NS_FAST
                                 + CLK_NS - 1) / CLK_NS;
   localparam int TX_FAST_END_CYC = (TX_FAST_END_BITS * BIT_NS_FAST
                                 + CLK_NS - 1) / CLK_NS;
   localparam int TX_SLOW_CYC = (TX_SLOW_LAT_HALF_BITS * BIT_NS_SLOW / 2
                                 + CLK_NS - 1) / CLK_NS;
   localparam int CRS_ON_FAST_CYC = (RX_CRS_ON_FAST_BITS * BIT_NS_FAST
                                 + CLK_NS - 1) / CLK_NS;
   localparam int DATA_FAST_CYC = (RX_DATA_FAST_BITS * BIT_NS_FAST
                                 + CLK_NS - 1) / CLK_NS;
   localparam int CRS_OFF_FAST_CYC = (RX_CRS_OFF_FAST_BITS * BIT_NS_FAST
                                 + CLK_NS - 1) / CLK_NS;
   localparam int CRS_ON_SLOW_CYC = (RX_CRS_ON_SLOW_NS + CLK_NS - 1)
                                    / CLK_NS;
   localparam int CRS_ON_SLOW_MAX_CYC = RX_CRS_ON_SLOW_MAX_NS / CLK_NS;
   localparam int DV_SLOW_CYC = (RX_DV_SLOW_BITS * BIT_NS_SLOW
                                 + CLK_NS - 1) / CLK_NS;
   localparam int EOP_CYC     = (EOP_NOM_NS + CLK_NS - 1) / CLK_NS;
   localparam int EOP_MIN_CYC = (EOP_MIN_NS + CLK_NS - 1) / CLK_NS;
   // longest phase rounds down, least phase rounds up
   localparam int RXCLK_HI_CYC   = RXCLK_FAST_HI_NS / CLK_NS;
   localparam int RXCLK_LO_CYC   = (RXCLK_FAST_LO_NS + CLK_NS - 1) / CLK_NS;
   localparam int RXCLK_SLOW_CYC = RXCLK_SLOW_PH_NS / CLK_NS;
   localparam int RXCLK_FAST_MIN_CYC = (RXCLK_FAST_MIN_NS + CLK_NS - 1)
                                       / CLK_NS;
   localparam int RXCLK_SLOW_MIN_CYC = (RXCLK_SLOW_MIN_NS + CLK_NS - 1)
                                       / CLK_NS;

   // ---------------------------------------------------------------
   // counter widths and synchroniser bit positions
   // ---------------------------------------------------------------
   localparam int PH_W   = 5;
   localparam int EOP_W  = 6;
   localparam int SYN_W  = 12;
   localparam int SY_TXCLK = 0;
   localparam int SY_TXEN  = 1;
   localparam int SY_TXD   = 2;
   localparam int SY_RXACT = 6;
   localparam int SY_RXD   = 7;
   localparam int SY_SPD   = 11;
endpackage : mii_timing_pkg

//--- hw/pulse_delay.sv
// fixed-length shift delay line for levels and pulses
module pulse_delay #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 1
) (
   input  wire logic             core_clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] data_in,
   output logic      [WIDTH-1:0] data_out
);
   logic [WIDTH-1:0] stage_ff  [DEPTH];
   logic [WIDTH-1:0] nxt_stage [DEPTH];

   // ---------------------------------------------------------------
   // one register per stage; a counter would lose back-to-back events
   // ---------------------------------------------------------------
   for (genvar g = 0; g < DEPTH; g++) begin : g_stage
      if (g == 0) begin : g_head
         always_comb begin
            nxt_stage[g] = data_in;
         end
      end else begin : g_tail
         always_comb begin
            nxt_stage[g] = stage_ff[g-1];
         end
      end
      always_ff @(posedge core_clk_in) begin
         if (sys_rst_in) begin
            stage_ff[g] <= '0;
         end else begin
            stage_ff[g] <= nxt_stage[g];
         end
      end
   end

   assign data_out = stage_ff[DEPTH-1];
endmodule : pulse_delay

//--- testbench/mii_mac_model.sv
// mac-side partner: free-running tx clock and mii transmit nibbles
module mii_mac_model (
   output logic       tx_clk_out,
   output logic       tx_en_out,
   output logic [3:0] txd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] nib_q[$];
   realtime    t_on;
   realtime    t_off;

   // ----------------------------------------------------------------
   // tx clock, phase unrelated to the core clock
   // ----------------------------------------------------------------
   initial begin
      tx_clk_out = 1'b0;
      tx_en_out  = 1'b0;
      txd_out    = 4'h0;
      t_on       = 0.0;
      t_off      = 0.0;
      #3.1;
      forever #62.5 tx_clk_out = ~tx_clk_out;
   end

   // updates just after the rising edge so the falling edge sees them stable
   always @(posedge tx_clk_out) begin
      #2;
      if (nib_q.size() > 0) begin
         if (!tx_en_out) t_on = $realtime - 2.0;
         tx_en_out = 1'b1;
         txd_out   = nib_q.pop_front();
      end else begin
         if (tx_en_out) t_off = $realtime - 2.0;
         tx_en_out = 1'b0;
         txd_out   = ~txd_out;           // idle nibble is not held
      end
   end

   task automatic push(input logic [3:0] d);
      nib_q.push_back(d);
   endtask : push
endmodule : mii_mac_model

//--- testbench/test_mii_phy_timing.sv
// self-checking bench for the mii latency timing model
module test_mii_phy_timing;
   timeunit 1ns;
   timeprecision 100ps;
   import mii_timing_pkg::*;
   logic             core_clk_in, sys_rst_in, tx_clk, tx_en, speed_10;
   logic             rx_act, j, t, act, eop, crs, dv, rxc;
   logic             act_q, eop_q, crs_q, dv_q, rxc_q;
   logic [NIB_W-1:0] txd, rx_nib, line_txd, rxd, rxd_dv, txd_j;
   int               miscompares, samples_checked, cyc, spd_cyc, run_len;
   int               n_j, n_t;
   realtime          t_j, t_t, t_act_r, t_act_f, t_eop_r, t_eop_f;
   realtime          t_crs_r, t_crs_f, t_dv_r, t_rr, t_rf;

   mii_phy_timing dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .tx_clk_in(tx_clk), .tx_en_in(tx_en), .txd_in(txd),
      .speed_10_in(speed_10), .line_rx_act_in(rx_act),
      .line_rxd_in(rx_nib), .line_j_out(j), .line_t_out(t),
      .line_tx_active_out(act), .line_txd_out(line_txd),
      .line_eop_out(eop), .crs_out(crs), .rx_dv_out(dv), .rxd_out(rxd),
      .rx_clk_out(rxc));
   mii_mac_model mac (.tx_clk_out(tx_clk), .tx_en_out(tx_en),
      .txd_out(txd));

   // ----------------------------------------------------------------
   // clock and timeout
   // ----------------------------------------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   // cuts a hang short; the run needs well under a third of this
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         give_verdict();
      end
   end

   // edge times of the outputs, taken mid-cycle where they are settled
   always @(negedge core_clk_in) begin
      if (j === 1'b1) begin
         t_j   = $realtime;
         txd_j = line_txd;
         n_j++;
      end
      if (t === 1'b1) begin t_t = $realtime; n_t++; end
      if (act === 1'b1 && act_q !== 1'b1) t_act_r = $realtime;
      if (act !== 1'b1 && act_q === 1'b1) t_act_f = $realtime;
      if (eop === 1'b1 && eop_q !== 1'b1) t_eop_r = $realtime;
      if (eop !== 1'b1 && eop_q === 1'b1) t_eop_f = $realtime;
      if (crs === 1'b1 && crs_q !== 1'b1) t_crs_r = $realtime;
      if (crs !== 1'b1 && crs_q === 1'b1) t_crs_f = $realtime;
      if (dv === 1'b1 && dv_q !== 1'b1) begin
         t_dv_r = $realtime;
         rxd_dv = rxd;
      end
      if (rxc !== rxc_q) begin
         // a speed change legitimately cuts a phase, so wait it out
         if (spd_cyc > 300) chk_eq("rx clk phase ok", 1, run_len >=
            (speed_10 ? RXCLK_SLOW_MIN_CYC : RXCLK_FAST_MIN_CYC));
         run_len = 1;
      end else run_len++;
      spd_cyc++;
      {act_q, eop_q, crs_q, dv_q, rxc_q} = {act, eop, crs, dv, rxc};
   end

   // ----------------------------------------------------------------
   // expectations and comparisons
   // ----------------------------------------------------------------
   function automatic int ceil_cyc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction : ceil_cyc

   // input sync adds about four cycles, so allow lat+3 to lat+5
   task automatic chk_lat(input string what, input realtime dt,
                          input int lat);
      real c;
      c = dt / CLK_NS;
      samples_checked++;
      if (c < lat + 3 || c > lat + 5) begin
         miscompares++;
         $display("wrong value %s expected %0d seen %0.1f", what, lat + 4, c);
      end
   endtask : chk_lat

   task automatic chk_eq(input string what, input logic [31:0] e,
                         input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk_eq

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   task automatic tx_test(input int n, input bit b2b);
      realtime          half;
      logic [NIB_W-1:0] nib, first;
      n_j = 0;
      n_t = 0;
      for (int f = 0; f <= int'(b2b); f++) begin
         for (int i = 0; i < n; i++) begin
            nib = NIB_W'($urandom);
            if (i == 0) first = nib;
            mac.push(nib);
         end
         wait (tx_en === 1'b1);
         wait (tx_en === 1'b0);
      end
      repeat (120) @(negedge core_clk_in);
      half = speed_10 ? 62.5 : 125.0;
      if (!speed_10) begin
         chk_lat("j code", t_j - mac.t_on - half,
                 ceil_cyc(TX_FAST_LAT_BITS * BIT_NS_FAST));
         chk_lat("t code", t_t - mac.t_off - half,
                 ceil_cyc(TX_FAST_END_BITS * BIT_NS_FAST));
         chk_eq("j count", b2b ? 2 : 1, n_j);
         chk_eq("t count", b2b ? 2 : 1, n_t);
         // the nibble launched with tx_en must be the one taken
         chk_eq("tx nibble", first, txd_j);
      end else begin
         chk_lat("tx start", t_act_r - mac.t_on - half,
                 ceil_cyc(TX_SLOW_LAT_HALF_BITS * BIT_NS_SLOW / 2));
         chk_lat("tx stop", t_act_f - mac.t_off - half,
                 ceil_cyc(TX_SLOW_LAT_HALF_BITS * BIT_NS_SLOW / 2));
         chk_eq("eop start", 0, int'((t_eop_r - t_act_f) / CLK_NS));
         chk_eq("eop length", ceil_cyc(EOP_NOM_NS),
                int'((t_eop_f - t_eop_r) / CLK_NS));
      end
      $display("tx test done, %0d nibbles", n);
   endtask : tx_test

   task automatic rx_test(input int len);
      logic [NIB_W-1:0] nib;
      nib = NIB_W'($urandom);
      @(negedge core_clk_in);
      rx_act = 1'b1;
      rx_nib = nib;
      t_rr   = $realtime;
      repeat (len) @(negedge core_clk_in);
      rx_act = 1'b0;
      rx_nib = ~nib;
      t_rf   = $realtime;
      repeat (200) @(negedge core_clk_in);
      if (speed_10) begin
         chk_lat("crs on", t_crs_r - t_rr, ceil_cyc(RX_CRS_ON_SLOW_NS));
         chk_lat("dv on", t_dv_r - t_rr,
                 ceil_cyc(RX_DV_SLOW_BITS * BIT_NS_SLOW));
         chk_lat("crs off", t_crs_f - t_rf, ceil_cyc(1000));
      end else begin
         chk_lat("crs on", t_crs_r - t_rr,
                 ceil_cyc(RX_CRS_ON_FAST_BITS * BIT_NS_FAST));
         chk_lat("dv on", t_dv_r - t_rr,
                 ceil_cyc(RX_DATA_FAST_BITS * BIT_NS_FAST));
         chk_lat("crs off", t_crs_f - t_rf,
                 ceil_cyc(RX_CRS_OFF_FAST_BITS * BIT_NS_FAST));
      end
      chk_eq("rx nibble", nib, rxd_dv);
      $display("rx test done, %0d cycles", len);
   endtask : rx_test

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   // main sequence: 100 mb/s first, then 10 mb/s
   initial begin
      sys_rst_in = 1'b1;
      speed_10   = 1'b0;
      rx_act     = 1'b0;
      rx_nib     = 4'h0;
      void'($urandom(32'h2526));
      repeat (8) @(negedge core_clk_in);
      sys_rst_in = 1'b0;
      for (int s = 0; s < 2; s++) begin
         speed_10 = s[0];
         spd_cyc  = 0;
         repeat (20) @(negedge core_clk_in);
         tx_test(1, 1'b0);
         tx_test(1 + $urandom % 6, s == 0);
         for (int i = 0; i < 4; i++) begin
            tx_test(1 + $urandom % 6, 1'b0);
            rx_test(s == 1 ? 140 + $urandom % 60 : 40 + $urandom % 40);
         end
      end
      give_verdict();
   end
endmodule : test_mii_phy_timing
